/* File: src/asrc_counter.sv */
`timescale 1ns/1ns
module asrc_counter
	import asrc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       load,
	input  wire logic [3:0] loadVal,
	output logic            done
);
	logic [3:0] count_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_r <= 4'h0;
		end else if (load) begin
			count_r <= loadVal;
		end else if (count_r != 4'h0) begin
			count_r <= count_r - CNT_ONE;
		end
	end

	assign done = (count_r <= CNT_ONE) && !load;
endmodule : asrc_counter

/* File: src/asrc_host.sv */
// What this block does
// RQ1 - drives 16-bit word index and shares one 16-bit data bus
// RQ2 - memory has no clock; host shapes every cycle by pin levels
// RQ3 - each byte lane has its own active-low enable
// RQ4 - select held high while idle puts memory in standby
// RQ5 - store strobe high with drive high floats the memory lanes
// RQ6 - read: drive low, strobe high, only enabled lanes return data
// RQ7 - write: only lanes with low enable take data
// RQ8 - store strobe stays high for the whole read cycle
// RQ9 - write happens only while select, strobe and lane enable are low
// RQ10 - write opens on later fall of select or strobe
// RQ11 - write closes on earlier rise of select or strobe
// RQ12 - select falling with or after strobe keeps memory outputs floating
// RQ13 - host never drives the bus while memory output drive is on
// RQ14 - after a write, reads return the newly addressed word
// RQ15 - strobe pulse at least 10 ns with drive low, 7 ns otherwise
// RQ16 - at least 10 ns between successive reads and writes
// RQ17 - disabled lane keeps its old contents in a partial write
`timescale 1ns/1ns
module asrc_host
	import asrc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              reqValid,
	output logic                   reqReady,
	input  wire asrc_req_t         req,
	output logic                   rdValid,
	output logic [DATA_W-1:0]      rdData,
	output asrc_pins_t             pins,
	input  wire logic [DATA_W-1:0] sharedDataLinesIn,
	output logic [DATA_W-1:0]      sharedDataLinesOut,
	output logic [DATA_W-1:0]      sharedDataLinesOe
);
	asrc_state_t state_r;
	asrc_state_t state_nxt;
	asrc_req_t   cur_r;
	logic        cntLoad;
	logic [3:0]  cntVal;
	logic        cntDone;
	logic        rdValid_r;
	logic [DATA_W-1:0] rdData_r;
	logic        selectN_r;
	logic        strobeN_r;
	logic        driveN_r;
	logic        laneLoN_r;
	logic        laneHiN_r;
	logic [ADDR_W-1:0] wordIndex_r;
	logic [DATA_W-1:0] dOut_r;
	logic [DATA_W-1:0] dOe_r;

	function automatic logic [DATA_W-1:0] asrc_lane_mask(input logic [1:0] en);
		return {{(DATA_W-LANE_HI_LSB){en[1]}}, {(LANE_LO_MSB+1){en[0]}}};
	endfunction : asrc_lane_mask

	function automatic logic asrc_in_access(input asrc_state_t s);
		return (s == ST_STROBE) || (s == ST_SAMPLE);
	endfunction : asrc_in_access

	asrc_counter u_cnt (
		.clk     (clk),
		.arst_n  (arst_n),
		.load    (cntLoad),
		.loadVal (cntVal),
		.done    (cntDone)
	);

	// one transfer at a time: a new request waits until the gap has run out
	assign reqReady = (state_r == ST_IDLE);

	always_comb begin
		state_nxt = state_r;
		cntLoad = 1'b0;
		cntVal = 4'h0;
		case (state_r)
			ST_IDLE: begin
				if (reqValid) begin
					state_nxt = ST_SETUP;
				end
			end
			ST_SETUP: begin
				state_nxt = ST_STROBE;
				cntLoad = 1'b1;
				cntVal = cur_r.write ? 4'(STROBE_CYC) : 4'(ACCESS_CYC); // [RQ15]
			end
			ST_STROBE: begin
				if (cntDone) begin
					state_nxt = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				state_nxt = ST_GAP;
				cntLoad = 1'b1;
				cntVal = 4'(GAP_CYC); // [RQ16]
			end
			ST_GAP: begin
				if (cntDone) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_r <= '0;
		end else if (state_r == ST_IDLE && reqValid) begin
			cur_r <= req;
		end
	end

	// select and strobe fall on the same edge: a write opens there and the memory
	// outputs never leave high impedance during it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			selectN_r <= 1'b1; // [RQ4]
		end else if (asrc_in_access(state_nxt)) begin
			selectN_r <= 1'b0; // [RQ10]
		end else begin
			selectN_r <= 1'b1; // [RQ11] [RQ4]
		end
	end

	// a read keeps the strobe high throughout; a write holds it low for the whole access
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strobeN_r <= 1'b1;
		end else if (asrc_in_access(state_nxt)) begin
			strobeN_r <= !cur_r.write; // [RQ8] [RQ9] [RQ12] [RQ15]
		end else begin
			strobeN_r <= 1'b1;
		end
	end

	// output drive stays high on writes; the write strobe is still sized from the 10 ns drive-on figure, not the 7 ns one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			driveN_r <= 1'b1;
		end else if (asrc_in_access(state_nxt)) begin
			driveN_r <= cur_r.write; // [RQ6]
		end else begin
			driveN_r <= 1'b1; // [RQ5]
		end
	end

	// index and lanes come from the request taken on this very edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wordIndex_r <= '0;
		end else if (state_nxt == ST_SETUP) begin
			wordIndex_r <= req.wordIndex; // [RQ1]
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			laneLoN_r <= 1'b1;
			laneHiN_r <= 1'b1;
		end else if (state_nxt == ST_SETUP) begin
			laneLoN_r <= !req.laneEn[0]; // [RQ3]
			laneHiN_r <= !req.laneEn[1]; // [RQ17]
		end else if (!asrc_in_access(state_nxt)) begin
			laneLoN_r <= 1'b1;
			laneHiN_r <= 1'b1;
		end
	end

	// write data sits on the bus from setup until the host is idle again,
	// well past the closing edge of select and strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dOut_r <= '0;
		end else if (state_nxt == ST_SETUP && req.write) begin
			dOut_r <= req.wrData;
		end
	end

	// host drives only enabled lanes of a write, never during a read
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dOe_r <= '0;
		end else if (state_nxt == ST_SETUP && req.write) begin
			dOe_r <= asrc_lane_mask(req.laneEn); // [RQ7]
		end else if (state_nxt == ST_SETUP || state_nxt == ST_IDLE) begin
			dOe_r <= '0; // [RQ13]
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdValid_r <= 1'b0;
		end else begin
			rdValid_r <= (state_r == ST_SAMPLE) && !cur_r.write;
		end
	end

	// disabled read lanes float at the memory, so they are masked to zero here
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_r <= '0;
		end else if (state_r == ST_SAMPLE && !cur_r.write) begin
			rdData_r <= sharedDataLinesIn & asrc_lane_mask(cur_r.laneEn); // [RQ14]
		end
	end

	assign pins = '{selectN: selectN_r, strobeN: strobeN_r, driveN: driveN_r,
		lowLaneEnableN: laneLoN_r, highLaneEnableN: laneHiN_r, wordIndex: wordIndex_r}; // [RQ2]
	assign sharedDataLinesOut = dOut_r;
	assign sharedDataLinesOe = dOe_r;
	assign rdValid = rdValid_r;
	assign rdData = rdData_r;
endmodule : asrc_host

/* File: src/asrc_pkg.sv */
package asrc_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int LANE_LO_MSB = 7;
	localparam int LANE_HI_LSB = 8;
	localparam int CLK_PERIOD_NS = 100;
	// fastest grade figures
	localparam int READ_CYCLE_NS = 10;
	localparam int WRITE_CYCLE_NS = 10;
	localparam int STROBE_WIDTH_DRIVE_OFF_NS = 7;
	localparam int STROBE_WIDTH_WITH_DRIVE_ON_NS = 10;
	localparam int DATA_OVERLAP_NS = 5;
	localparam int ACCESS_NS = 10;
	// least times round up, never under one cycle
	function automatic int asrc_min_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : asrc_min_cycles
	localparam int STROBE_CYC = asrc_min_cycles(STROBE_WIDTH_WITH_DRIVE_ON_NS);
	localparam int GAP_CYC = asrc_min_cycles(READ_CYCLE_NS);
	localparam int ACCESS_CYC = asrc_min_cycles(ACCESS_NS);
	localparam logic [3:0] CNT_ONE = 4'h1;

	typedef struct packed {
		logic              write;
		logic [1:0]        laneEn;
		logic [ADDR_W-1:0] wordIndex;
		logic [DATA_W-1:0] wrData;
	} asrc_req_t;

	typedef struct packed {
		logic              selectN;
		logic              strobeN;
		logic              driveN;
		logic              lowLaneEnableN;
		logic              highLaneEnableN;
		logic [ADDR_W-1:0] wordIndex;
	} asrc_pins_t;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_SETUP  = 5'h02,
		ST_STROBE = 5'h04,
		ST_SAMPLE = 5'h08,
		ST_GAP    = 5'h10
	} asrc_state_t;
endpackage : asrc_pkg

/* File: verification/asrc_host_checker.sv */
`timescale 1ns/1ns
module asrc_host_checker
	import asrc_pkg::*;
(
	input wire logic              clk,
	input wire logic              arst_n,
	input wire logic              reqValid,
	input wire logic              reqReady,
	input wire asrc_req_t         req,
	input wire logic              rdValid,
	input wire asrc_pins_t        pins,
	input wire logic [DATA_W-1:0] sharedDataLinesOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_rdStb; !pins.driveN |-> pins.strobeN; endproperty
	a_rdStb: assert property (p_rdStb) else $error("strobe in read");
	property p_noFight; !pins.driveN |-> sharedDataLinesOe == '0; endproperty
	a_noFight: assert property (p_noFight) else $error("bus fight");
	property p_stbW; $fell(pins.strobeN) |=> !pins.strobeN; endproperty
	a_stbW: assert property (p_stbW) else $error("short strobe");
	property p_gap; $rose(pins.selectN) |=> pins.selectN; endproperty
	a_gap: assert property (p_gap) else $error("no gap");
	property p_rdLat; reqValid && reqReady && !req.write |-> ##[4:5] rdValid; endproperty
	a_rdLat: assert property (p_rdLat) else $error("no read data");
	cover property (reqValid && reqReady && req.write);
	cover property (reqValid && reqReady && req.laneEn == 2'h1);
	cover property (rdValid);
endmodule : asrc_host_checker
bind asrc_host asrc_host_checker u_asrc_host_checker (.clk, .arst_n, .reqValid, .reqReady,
	.req, .rdValid, .pins, .sharedDataLinesOe);

/* File: verification/asrc_mem_model.sv */
`timescale 1ns/1ns
module asrc_mem_model
	import asrc_pkg::*;
(
	input  wire asrc_pins_t        pins,
	input  wire logic [DATA_W-1:0] busIn,
	output logic [DATA_W-1:0]      drv,
	output logic [DATA_W-1:0]      drvOe
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	wire               rd = !pins.selectN && pins.strobeN && !pins.driveN;
	assign drvOe = {{8{rd && !pins.highLaneEnableN}},
		{8{rd && !pins.lowLaneEnableN}}};
	assign drv = mem[pins.wordIndex];
	always @(pins or busIn) begin
		if (!pins.selectN && !pins.strobeN) begin
			if (!pins.lowLaneEnableN) mem[pins.wordIndex][7:0] = busIn[7:0];
			if (!pins.highLaneEnableN) mem[pins.wordIndex][15:8] = busIn[15:8];
		end
	end
endmodule : asrc_mem_model

/* File: verification/test_async_sram_64kx16_byte_lanes.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin cmpCount++; if ((a) !== (e)) begin errors++; \
	$display("MISMATCH %0t %h %h", $time, a, e); end end
module test_async_sram_64kx16_byte_lanes
	import asrc_pkg::*;
;
	logic              clk = 0, arst_n = 0, reqValid = 0, reqReady, rdValid;
	asrc_req_t         req = '0;
	asrc_pins_t        pins;
	logic [DATA_W-1:0] rdData, hOut, hOe, mDrv, mOe, busQ = '0;
	wire [DATA_W-1:0]  bus;
	int                errors = 0, cmpCount = 0, n;
	logic [50:0]       rows [8] = '{
		{1'b1, 2'h3, 16'h0001, 16'hA5C3, 16'h0},
		{1'b0, 2'h3, 16'h0001, 16'h0, 16'hA5C3},
		{1'b1, 2'h1, 16'h0001, 16'h1122, 16'h0},
		{1'b0, 2'h3, 16'h0001, 16'h0, 16'hA522},
		{1'b1, 2'h2, 16'hFFFF, 16'h7788, 16'h0},
		{1'b0, 2'h2, 16'hFFFF, 16'h0, 16'h7700},
		{1'b0, 2'h1, 16'h0001, 16'h0, 16'h0022},
		{1'b0, 2'h0, 16'h0001, 16'h0, 16'h0}};
	// board delay keeps write data past the closing control edge
	assign #1 bus = hOe & hOut | mOe & mDrv | ~hOe & ~mOe & ~busQ;
	always #50 clk = ~clk;
	// released lines show the inverse of their last level, from a known start
	always @(posedge clk) busQ <= arst_n ? bus : '0;
	asrc_host u_asrc_host (.clk, .arst_n, .reqValid, .reqReady, .req, .rdValid, .rdData, .pins,
		.sharedDataLinesIn(bus), .sharedDataLinesOut(hOut), .sharedDataLinesOe(hOe));
	asrc_mem_model u_asrc_mem_model (.pins, .busIn(bus), .drv(mDrv), .drvOe(mOe));
	task automatic wrap_up(input int late);
		errors += late;
		if (errors == 0 && cmpCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic waitReady();
		for (n = 0; n < 9 && !reqReady; n++) @(posedge clk) #1;
		if (n == 9) wrap_up(1);
	endtask : waitReady
	task automatic doReq(input logic [50:0] r);
		req = r[50:16];
		reqValid = 1;
		waitReady();
		@(posedge clk) #1;
		reqValid = 0;
		// a write waits for idle so reqValid never drops and rises in one step
		for (n = 0; n < 9 && (r[50] ? !reqReady : !rdValid); n++) @(posedge clk) #1;
		if (n == 9) wrap_up(1);
		if (!r[50]) `CHK(rdData, r[15:0])
	endtask : doReq
	initial begin
		repeat (6) @(posedge clk);
		`CHK({pins.selectN, pins.strobeN, reqReady, hOe}, 19'h70000)
		#1 arst_n = 1;
		foreach (rows[i]) doReq(rows[i]);
		req = {1'b1, 2'h3, 16'h0001, 16'h0000};
		waitReady();
		reqValid = 1;
		@(posedge clk) #1;
		reqValid = 0;
		arst_n = 0;
		#1 `CHK({pins.selectN, hOe}, 17'h10000)
		@(posedge clk) #1;
		arst_n = 1;
		doReq(rows[3]);
		wrap_up(0);
	end
endmodule : test_async_sram_64kx16_byte_lanes
